//--- verilog/ctx_pkg.sv
package ctx_pkg;
  // Register word indices (printed offsets not all multiples of four)
  localparam logic [7:0] idx_state_status = 8'h01;
  localparam logic [7:0] idx_state_command = 8'h02;
  localparam logic [7:0] idx_tx_control = 8'h04;
  localparam logic [7:0] idx_raw_cfg_a = 8'h0a;
  localparam logic [7:0] idx_raw_cfg_b = 8'h0c;
  localparam logic [7:0] idx_interrupt_mask = 8'h0e;
  localparam logic [7:0] idx_interrupt_status = 8'h0f;
  localparam logic [7:0] idx_test_mode_unlock = 8'h1c;
  localparam logic [7:0] idx_continuous_tx_enable = 8'h36;
  // Block's own registers
  localparam logic [7:0] idx_irq_clear = 8'h40;
  localparam logic [7:0] idx_fb_addr = 8'h41;
  localparam logic [7:0] idx_fb_data = 8'h42;
  localparam logic [7:0] idx_lock_count = 8'h43;
  // Reset values
  localparam logic [7:0] rst_tx_control = 8'h00;
  localparam logic [7:0] rst_raw_cfg_a = 8'h37;
  localparam logic [7:0] rst_raw_cfg_b = 8'h20;
  localparam logic [7:0] rst_unlock = 8'h0b;
  // Command and status codes
  localparam logic [7:0] cmd_tx_start = 8'h02;
  localparam logic [7:0] cmd_radio_off = 8'h03;
  localparam logic [7:0] cmd_pll_on = 8'h09;
  localparam logic [7:0] st_p_on = 8'h00;
  localparam logic [7:0] st_busy_tx = 8'h02;
  localparam logic [7:0] st_radio_off = 8'h08;
  localparam logic [7:0] st_pll_on = 8'h09;
  localparam logic [3:0] ctx_enable_code = 4'hf;
  localparam logic [7:0] unlock_step2 = 8'h54;
  localparam logic [7:0] unlock_step3 = 8'h46;
  localparam logic [7:0] raw_b_code = 8'h03;
  localparam logic [7:0] raw_a_code = 8'h37;
  localparam logic [7:0] byte_zero = 8'h00;
  localparam logic [7:0] byte_ones = 8'hff;
  localparam int irq_lock_bit = 0;
  localparam int irq_tx_start_bit = 1;
  localparam int irq_bits = 2;
  localparam int fb_depth = 128;
  localparam int fb_aw = 7;
  // Synthesizer settle time
  localparam int pll_lock_ns = 1000;
  localparam int clk_period_ns = 25;
  localparam int pll_lock_cycles = (pll_lock_ns + clk_period_ns - 1) / clk_period_ns;
  // Tone selection
  typedef enum logic [1:0] {
    tone_none = 2'h0,
    tone_low = 2'h1,
    tone_high = 2'h2
  } tone_t;
endpackage

//--- verilog/fb_read_if.sv
`timescale 1ns/1ps
interface fb_read_if;
  logic [ctx_pkg::fb_aw-1:0] rd_addr;
  logic [7:0] rd_data;
  modport streamer (output rd_addr, input rd_data);
  modport buffer (input rd_addr, output rd_data);
endinterface

//--- verilog/psdu_streamer.sv
`timescale 1ns/1ps
module psdu_streamer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [7:0] frame_len,
  fb_read_if.streamer fb,
  output logic [7:0] tx_byte,
  output logic tx_valid
);
  import ctx_pkg::*;

  logic [fb_aw-1:0] pos;
  wire logic [fb_aw-1:0] last_pos = (frame_len[6:0] == 7'h00) ? 7'h00 : frame_len[6:0];
  wire logic wrap = (pos >= last_pos);

  assign fb.rd_addr = pos;

  // Walk PSDU bytes 1..len, skipping the length byte, then loop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos <= 7'h01;
      tx_byte <= 8'h00;
      tx_valid <= 1'b0;
    end else if (run) begin
      tx_byte <= fb.rd_data;
      tx_valid <= 1'b1;
      pos <= wrap ? 7'h01 : pos + 7'h01;
    end else begin
      pos <= 7'h01;
      tx_valid <= 1'b0;
    end
  end
endmodule // psdu_streamer

//--- verilog/continuous_tx_test_mode.sv
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
// Summary of operation
// - Test mode sends only PSDU bytes from buffer, looping, no sync or PHY header.
// - Tone is centre plus or minus half megahertz, never centre.
// - All PSDU bytes zero gives tone at centre minus half megahertz.
// - All PSDU bytes 0xff gives tone at centre plus half megahertz.
// - Transmit start with synthesizer locked enters busy transmit, continuous.
module continuous_tx_test_mode (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic [7:0] tx_byte,
  output logic tx_valid,
  output ctx_pkg::tone_t tone_sel,
  output logic carrier_on
);
  import ctx_pkg::*;

  typedef enum logic [3:0] {
    s_p_on = 4'b0001,
    s_off = 4'b0010,
    s_pll = 4'b0100,
    s_busy = 4'b1000
  } radio_state_t;

  radio_state_t state;
  radio_state_t next_state;
  logic [7:0] state_command;
  logic [7:0] tx_control;
  logic [7:0] raw_cfg_a;
  logic [7:0] raw_cfg_b;
  logic [7:0] interrupt_mask;
  logic [irq_bits-1:0] interrupt_status;
  logic [7:0] test_mode_unlock;
  logic [3:0] continuous_tx_enable;
  logic [fb_aw-1:0] fb_wptr;
  logic [7:0] fb_mem [fb_depth];
  logic [7:0] lock_cnt;
  logic locked;
  logic step2_seen;
  logic armed;
  logic all_zero;
  logic all_ones;

  fb_read_if fbr ();

  // Bus decode
  wire logic [7:0] idx = paddr[9:2];
  wire logic aligned = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h000000);
  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite && pstrb[0];
  wire logic known = aligned && (idx == idx_state_status || idx == idx_state_command ||
    idx == idx_tx_control || idx == idx_raw_cfg_a || idx == idx_raw_cfg_b ||
    idx == idx_interrupt_mask || idx == idx_interrupt_status ||
    idx == idx_test_mode_unlock || idx == idx_continuous_tx_enable ||
    idx == idx_irq_clear || idx == idx_fb_addr || idx == idx_fb_data ||
    idx == idx_lock_count);
  wire logic w_cmd = wr && aligned && idx == idx_state_command;
  wire logic w_fb = wr && aligned && idx == idx_fb_data;
  wire logic w_unl = wr && aligned && idx == idx_test_mode_unlock;
  wire logic w_clr = wr && aligned && idx == idx_irq_clear;
  wire logic [7:0] wbyte = pwdata[7:0];

  assign pready = 1'b1;
  assign pslverr = acc && !known;

  // Mode decode
  wire logic mode_on = armed && continuous_tx_enable == ctx_enable_code;
  wire logic cw_mode = raw_cfg_b == raw_b_code && raw_cfg_a == raw_a_code;
  wire logic lock_evt = state == s_pll && !locked && lock_cnt == 8'(pll_lock_cycles - 1);
  wire logic start_evt = w_cmd && wbyte == cmd_tx_start && state == s_pll && locked;
  wire logic [irq_bits-1:0] evt_vec = {start_evt, lock_evt};

  // Radio state transitions
  always_comb begin
    next_state = state;
    case (state)
      s_p_on: if (w_cmd && wbyte == cmd_radio_off) next_state = s_off;
      s_off: if (w_cmd && wbyte == cmd_pll_on) next_state = s_pll;
      s_pll: begin
        if (start_evt) next_state = s_busy;
        else if (w_cmd && wbyte == cmd_radio_off) next_state = s_off;
      end
      s_busy: begin
        if (!mode_on) next_state = s_pll; // Busy ends, back to PLL on, when mode leaves
        else if (w_cmd && wbyte == cmd_radio_off) next_state = s_off;
      end
      default: next_state = s_p_on;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state <= s_p_on;
    else state <= next_state;
  end

  // Synthesizer settle counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cnt <= 8'h00;
      locked <= 1'b0;
    end else if (state != s_pll && state != s_busy) begin
      lock_cnt <= 8'h00;
      locked <= 1'b0;
    end else if (lock_evt) begin
      locked <= 1'b1;
    end else if (!locked) begin
      lock_cnt <= lock_cnt + 8'h01;
    end
  end

  // Plain configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_command <= 8'h00;
      tx_control <= rst_tx_control;
      raw_cfg_a <= rst_raw_cfg_a;
      raw_cfg_b <= rst_raw_cfg_b;
      interrupt_mask <= 8'h00;
      continuous_tx_enable <= 4'h0;
    end else if (wr && aligned) begin
      if (idx == idx_state_command) state_command <= wbyte;
      if (idx == idx_tx_control) tx_control <= wbyte;
      if (idx == idx_raw_cfg_a) raw_cfg_a <= wbyte;
      if (idx == idx_raw_cfg_b) raw_cfg_b <= wbyte;
      if (idx == idx_interrupt_mask) interrupt_mask <= wbyte;
      if (idx == idx_continuous_tx_enable) continuous_tx_enable <= wbyte[3:0];
    end
  end

  // Unlock sequence: 0x54 then 0x46 arms; every other write, 0x54 or a repeated 0x46 included, disarms
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_mode_unlock <= rst_unlock;
      step2_seen <= 1'b0;
      armed <= 1'b0;
    end else if (w_unl) begin
      test_mode_unlock <= wbyte;
      step2_seen <= wbyte == unlock_step2;
      armed <= (wbyte == unlock_step3) && step2_seen;
    end
  end

  // Sticky status, set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) interrupt_status <= '0;
    else interrupt_status <= (interrupt_status & ~(w_clr ? wbyte[irq_bits-1:0] : '0)) | evt_vec;
  end

  assign irq = |(interrupt_status & interrupt_mask[irq_bits-1:0]);

  // Frame buffer: byte 0 is the length, bytes 1..127 are the PSDU
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fb_wptr <= 7'h00;
    else if (wr && aligned && idx == idx_fb_addr) fb_wptr <= wbyte[fb_aw-1:0];
    else if (w_fb) fb_wptr <= fb_wptr + 7'h01;
  end

  always_ff @(posedge pclk) begin
    if (w_fb) fb_mem[fb_wptr] <= wbyte;
  end

  assign fbr.rd_data = fb_mem[fbr.rd_addr];

  // Scan PSDU content for tone selection
  always_comb begin
    all_zero = 1'b1;
    all_ones = 1'b1;
    for (int i = 1; i < fb_depth; i++) begin
      if (i <= int'(fb_mem[0][6:0])) begin
        if (fb_mem[i] != byte_zero) all_zero = 1'b0;
        if (fb_mem[i] != byte_ones) all_ones = 1'b0;
      end
    end
  end

  // Tone output, never on centre
  wire logic running = state == s_busy && mode_on;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tone_sel <= tone_none;
      carrier_on <= 1'b0;
    end else begin
      carrier_on <= running;
      if (!running || !cw_mode) tone_sel <= tone_none;
      else if (all_zero) tone_sel <= tone_low;
      else if (all_ones) tone_sel <= tone_high;
      else tone_sel <= tone_none;
    end
  end

  psdu_streamer u_stream (
    .pclk(pclk),
    .presetn(presetn),
    .run(running && !cw_mode),
    .frame_len(fb_mem[0]),
    .fb(fbr.streamer),
    .tx_byte(tx_byte),
    .tx_valid(tx_valid)
  );

  // State status code
  wire logic [7:0] status_code = state == s_off ? st_radio_off :
    state == s_pll ? st_pll_on : state == s_busy ? st_busy_tx : st_p_on;

  // Read mux
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite) begin
      case (idx)
        idx_state_status: prdata <= {24'h000000, status_code};
        idx_state_command: prdata <= {24'h000000, state_command};
        idx_tx_control: prdata <= {24'h000000, tx_control};
        idx_raw_cfg_a: prdata <= {24'h000000, raw_cfg_a};
        idx_raw_cfg_b: prdata <= {24'h000000, raw_cfg_b};
        idx_interrupt_mask: prdata <= {24'h000000, interrupt_mask};
        idx_interrupt_status: prdata <= {30'h00000000, interrupt_status};
        idx_test_mode_unlock: prdata <= {24'h000000, test_mode_unlock};
        idx_continuous_tx_enable: prdata <= {28'h0000000, continuous_tx_enable};
        idx_fb_addr: prdata <= {25'h0000000, fb_wptr};
        idx_lock_count: prdata <= {24'h000000, lock_cnt};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
endmodule // continuous_tx_test_mode

//--- tb/ctx_properties.sv
`timescale 1ns/1ps
module ctx_properties
  import ctx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic tx_valid,
  input wire ctx_pkg::tone_t tone_sel,
  input wire logic carrier_on
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Decoded write accesses
  wire logic wr_acc = psel && penable && pwrite;
  wire logic start_wr = wr_acc && paddr == {22'h0, idx_state_command, 2'b00}
    && pwdata[7:0] == cmd_tx_start;
  // Steps of leaving the mode and masking
  sequence mode_left;
    wr_acc && paddr == {22'h0, idx_test_mode_unlock, 2'b00} && pwdata[7:0] == 8'h00;
  endsequence
  sequence radio_quiet;
    !tx_valid && !carrier_on;
  endsequence
  sequence mask_cleared;
    wr_acc && paddr == {22'h0, idx_interrupt_mask, 2'b00} && pwdata[7:0] == 8'h00;
  endsequence
  a_ready_no_wait: assert property (psel && penable |-> pready)
    else $error("access phase without pready");
  a_error_in_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  a_tone_legal: assert property (tone_sel inside {tone_none, tone_low, tone_high})
    else $error("tone select holds an illegal code");
  a_tone_has_carrier: assert property (tone_sel != tone_none |-> carrier_on)
    else $error("tone selected without carrier");
  a_stream_after_start: assert property ($rose(tx_valid) |-> $past(start_wr, 2))
    else $error("stream began without a start command");
  a_stream_has_carrier: assert property (tx_valid |-> carrier_on)
    else $error("stream without carrier");
  // A stop command lands at the end of an access, so the cycle after one is exempt
  a_stream_endless: assert property (tx_valid && !psel && !$past(psel) |=> tx_valid)
    else $error("stream stopped on its own");
  a_exit_stops_radio: assert property (mode_left |-> ##[1:3] radio_quiet)
    else $error("radio still on after leaving the mode");
  a_mask_quiets_irq: assert property (mask_cleared |=> !irq)
    else $error("irq high with all sources masked");
endmodule // ctx_properties

//--- tb/ctx_host_model.sv
`timescale 1ns/1ps
module ctx_host_model
  import ctx_pkg::*;
(
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'h1;
  end
  // One transfer; released lines are scrambled so stale values never match
  task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d,
    output logic [7:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~paddr;
    pwdata <= ~pwdata;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] q;
    logic e;
    xfer(1'b1, i, d, q, e);
  endtask
  // Full setup and start sequence of the test mode
  task automatic run(input bit cw, input logic [7:0] len, input bit pat, input logic [7:0] fill,
    output logic [7:0] off_st, output int polls);
    logic [7:0] q;
    logic e;
    wr(idx_interrupt_mask, 8'h01);
    wr(idx_tx_control, 8'h00);
    wr(idx_state_command, cmd_radio_off);
    wr(8'h03, 8'h01);
    wr(8'h08, 8'h33);
    wr(8'h05, 8'h00);
    xfer(1'b0, idx_state_status, 8'h00, off_st, e);
    wr(idx_continuous_tx_enable, 8'h0f);
    if (cw) begin
      wr(idx_raw_cfg_b, raw_b_code);
      wr(idx_raw_cfg_a, raw_a_code);
    end
    wr(idx_fb_addr, 8'h00);
    wr(idx_fb_data, len);
    for (int k = 0; k < len; k++) begin
      wr(idx_fb_data, pat ? 8'(k * 37 + 11) : fill);
    end
    wr(idx_test_mode_unlock, unlock_step2);
    wr(idx_test_mode_unlock, unlock_step3);
    wr(idx_state_command, cmd_pll_on);
    polls = 0;
    q = 8'h00;
    while (q !== 8'h01 && polls < 200) begin
      xfer(1'b0, idx_interrupt_status, 8'h00, q, e);
      polls++;
    end
    wr(idx_state_command, cmd_tx_start);
  endtask
endmodule // ctx_host_model

//--- tb/continuous_tx_test_mode_tb.sv
`timescale 1ns/1ps
module continuous_tx_test_mode_tb;
  import ctx_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq, tx_valid, carrier_on;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] tx_byte;
  tone_t tone_sel;
  int miscompares = 0;
  int tests_run = 0;
  // 40 MHz clock
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  continuous_tx_test_mode DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .tx_byte(tx_byte), .tx_valid(tx_valid),
    .tone_sel(tone_sel), .carrier_on(carrier_on));
  ctx_host_model host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb));
  // Comparison helpers
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask
  task automatic rdc(input string name, input logic [7:0] i, input logic [7:0] exp);
    logic [7:0] q;
    logic e;
    host.xfer(1'b0, i, 8'h00, q, e);
    chk(name, exp, q);
  endtask
  task automatic reset_dut;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  // Reset values, read-only status and an unmapped place
  task automatic t_regs;
    logic [7:0] idx [8] = '{idx_raw_cfg_a, idx_raw_cfg_b, idx_test_mode_unlock, idx_interrupt_mask,
      idx_interrupt_status, idx_state_status, idx_state_command, idx_continuous_tx_enable};
    logic [7:0] rv [8] = '{8'h37, 8'h20, 8'h0b, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] q;
    logic e;
    for (int i = 0; i < 8; i++) begin
      rdc("reset_value", idx[i], rv[i]);
    end
    host.wr(idx_interrupt_status, 8'hff);
    rdc("status_read_only", idx_interrupt_status, 8'h00);
    host.xfer(1'b0, 8'h30, 8'h00, q, e);
    chk("unmapped_err", 8'h01, {7'h0, e});
    chk("unmapped_data", 8'h00, q);
    $display("register test done");
  endtask
  // One run of the mode, then leave it, mask and clear the interrupt
  task automatic t_mode(input bit cw, input logic [7:0] len, input bit pat,
    input logic [7:0] fill, input tone_t tone);
    logic [7:0] st;
    int n;
    host.run(cw, len, pat, fill, st, n);
    chk("off_state", st_radio_off, st);
    chk("lock_seen", 8'h01, 8'(n < 200));
    chk("lock_irq", 8'h01, {7'h0, irq});
    n = 0;
    while (tx_valid !== 1'b1 && !cw && n < 20) begin
      @(posedge pclk);
      #1;
      n++;
    end
    for (int k = 0; k < 140 && !cw; k++) begin
      chk("psdu_byte", 8'(k % len * 37 + 11), tx_byte);
      @(posedge pclk);
      #1;
    end
    repeat (3) @(posedge pclk);
    #1;
    chk("carrier", 8'h01, {7'h0, carrier_on});
    chk("tone", {6'h0, tone}, {6'h0, tone_sel});
    rdc("busy_state", idx_state_status, st_busy_tx);
    host.wr(idx_test_mode_unlock, 8'h00);
    repeat (3) @(posedge pclk);
    #1;
    chk("stopped", 8'h00, {6'h0, tx_valid, carrier_on});
    rdc("pll_state", idx_state_status, st_pll_on);
    host.wr(idx_interrupt_mask, 8'h00);
    #1;
    chk("irq_masked", 8'h00, {7'h0, irq});
    host.wr(idx_irq_clear, 8'h03);
    rdc("irq_cleared", idx_interrupt_status, 8'h00);
    $display("mode test done tone %0d", tone);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Main sequence; a reset precedes each run
  initial begin
    reset_dut();
    t_regs();
    t_mode(1'b0, 8'd127, 1'b1, 8'h00, tone_none);
    reset_dut();
    t_mode(1'b1, 8'd4, 1'b0, 8'h00, tone_low);
    reset_dut();
    t_mode(1'b1, 8'd4, 1'b0, 8'hff, tone_high);
    reset_dut();
    t_mode(1'b1, 8'd4, 1'b0, 8'h5a, tone_none);
    conclude();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    conclude();
  end
endmodule // continuous_tx_test_mode_tb
bind continuous_tx_test_mode ctx_properties props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .irq(irq), .tx_valid(tx_valid), .tone_sel(tone_sel), .carrier_on(carrier_on));
